// File: test_triple_timer_pin_io.sv
`timescale 1ns/1ps
module test_triple_timer_pin_io;
  import ttp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [2:0] ext_clk_in = 3'h0;
  logic stop_state = 1'b0;
  logic wait_state = 1'b0;
  // Pins held low through reset so the pin bit of the control word reads a known zero
  logic [2:0] drv_en = 3'h7;
  logic [2:0] drv_val = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [2:0] pin_o, pin_oe_n, pin_w;
  int errors = 0;
  int n_checks = 0;

  always #2 aclk = ~aclk;

  ttp_top #(.CNT_W(8), .PRESCALE(2)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timer0_pin_i(pin_w[0]), .timer0_pin_o(pin_o[0]),
    .timer0_pin_oe_n(pin_oe_n[0]), .timer1_pin_i(pin_w[1]), .timer1_pin_o(pin_o[1]),
    .timer1_pin_oe_n(pin_oe_n[1]), .timer2_pin_i(pin_w[2]), .timer2_pin_o(pin_o[2]),
    .timer2_pin_oe_n(pin_oe_n[2]), .ext_clk_in(ext_clk_in), .stop_state(stop_state),
    .wait_state(wait_state), .irq(irq));

  ttp_pin_partner partner (.aclk(aclk), .stop_state(stop_state), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .drv_en(drv_en), .drv_val(drv_val), .pin_w(pin_w));

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  // Holds each channel until its own handshake edge
  // Only the watchdog ends a wait that never gets its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
  endtask : rdr

  // Slow pulses so the two-flop synchronisers see every edge
  task automatic pulses(input bit ext, input int k, input int n);
    repeat (n) begin
      if (ext) ext_clk_in[k] <= 1'b1;
      else drv_val[k] <= 1'b1;
      cyc(4);
      if (ext) ext_clk_in[k] <= 1'b0;
      else drv_val[k] <= 1'b0;
      cyc(4);
    end
  endtask : pulses

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      chk("oe_n after reset", 1, pin_oe_n[i]);
      rdr(8'(16 * i));
      chk("ctrl reset", 32'h0, rd);
    end
    chk("irq after reset", 0, irq);
    rdr(8'h3c);
    chk("unmapped read resp", 32'(RESP_SLVERR), 32'(rsp));
    wr(8'h3c, 32'h1);
    chk("unmapped write resp", 32'(RESP_SLVERR), 32'(rsp));
    drv_en <= 3'h0;
  endtask : t_reset

  task automatic t_gpio();
    wr(8'h00, 32'h60);
    cyc(3);
    chk("gpio out oe_n", 0, pin_oe_n[0]);
    chk("gpio out level", 1, pin_w[0]);
    wr(8'h00, 32'h20);
    cyc(3);
    chk("gpio data low", 0, pin_o[0]);
    drv_en[2] <= 1'b1;
    drv_val[2] <= 1'b1;
    cyc(5);
    rdr(OFF_PINS);
    chk("pin level high", 1, rd[2]);
    rdr(8'h20);
    chk("ctrl pin bit", 32'h80, rd);
    drv_val[2] <= 1'b0;
    cyc(5);
    rdr(OFF_PINS);
    chk("pin level low", 0, rd[2]);
    drv_en[2] <= 1'b0;
  endtask : t_gpio

  task automatic t_modes();
    for (int m = 1; m < 6; m++) begin
      wr(8'h00, 32'(2 * m + 1));
      cyc(3);
      chk("mode pin direction", 32'(m >= 4), pin_oe_n[0]);
      wr(8'h00, 32'h0);
    end
  endtask : t_modes

  task automatic t_timer();
    int tog;
    logic prev;
    tog = 0;
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h3);
    prev = pin_o[0];
    repeat (64) begin
      @(posedge aclk);
      if (pin_o[0] !== prev) tog++;
      prev = pin_o[0];
    end
    chk("pin toggles in range", 1, 32'(tog >= 7 && tog <= 11));
    chk("masked irq", 0, irq);
    rdr(8'h1c);
    chk("idle timer count", 0, rd);
    wr(8'h00, 32'h0);
    wr(OFF_MASK, 32'h1);
    cyc(2);
    chk("irq unmasked", 1, irq);
    rdr(OFF_STATUS);
    chk("status bit", 32'h1, rd);
    cyc(2);
    chk("irq after clear", 0, irq);
    rdr(OFF_STATUS);
    chk("status cleared", 32'h0, rd);
    // Watchdog wraps with the interrupt already unmasked
    wr(8'h00, 32'h7);
    cyc(16);
    chk("watchdog pin set", 1, pin_o[0]);
    chk("irq live event", 1, irq);
    wr(8'h00, 32'h0);
    rdr(OFF_STATUS);
    chk("status live event", 32'h1, rd);
  endtask : t_timer

  task automatic t_event();
    // Drive the pin before enabling so no floating edge is counted
    drv_en[1] <= 1'b1;
    cyc(2);
    wr(8'h10, 32'h9);
    pulses(0, 1, 5);
    rdr(8'h1c);
    chk("event count", 32'h5, rd);
    chk("event pin input", 1, pin_oe_n[1]);
    wr(8'h20, 32'h13);
    pulses(1, 2, 4);
    rdr(8'h2c);
    chk("external clock count", 32'h4, rd);
    wr(8'h20, 32'h0);
  endtask : t_event

  task automatic t_stop_wait();
    wr(8'h00, 32'h60);
    cyc(3);
    stop_state <= 1'b1;
    cyc(3);
    chk("stop driver off", 1, pin_oe_n[0]);
    chk("stop level kept", 1, pin_w[0]);
    pulses(0, 1, 3);
    stop_state <= 1'b0;
    cyc(3);
    chk("driver back", 0, pin_oe_n[0]);
    rdr(8'h1c);
    chk("stop input ignored", 32'h5, rd);
    wait_state <= 1'b1;
    cyc(3);
    chk("wait oe_n", 0, pin_oe_n[0]);
    chk("wait level", 1, pin_o[0]);
    wait_state <= 1'b0;
    cyc(3);
    chk("after wait level", 1, pin_o[0]);
  endtask : t_stop_wait

  initial begin
    cyc(12);
    aresetn <= 1'b1;
    t_reset();
    t_gpio();
    t_modes();
    t_timer();
    t_event();
    t_stop_wait();
    report_and_stop();
  end

  // Run needs about 400 cycles
  initial begin
    #40000;
    errors++;
    report_and_stop();
  end
endmodule : test_triple_timer_pin_io

// File: ttp_chan_if.sv
`timescale 1ns/1ps
interface ttp_chan_if #(parameter int CNT_W = 32);
  import ttp_pkg::*;
  logic en;
  ttp_mode_t mode;
  logic ext_sel;
  logic dir;
  logic data;
  logic [CNT_W-1:0] cmp;
  logic [CNT_W-1:0] duty;
  logic tick;
  logic pin_in;
  logic ext_in;
  logic stop;
  logic [CNT_W-1:0] count;
  logic event_p;
  logic pin_o;
  logic pin_oe_n;

  modport ctl (output en, mode, ext_sel, dir, data, cmp, duty, tick, pin_in, ext_in, stop,
               input count, event_p, pin_o, pin_oe_n);
  modport tmr (input en, mode, ext_sel, dir, data, cmp, duty, tick, pin_in, ext_in, stop,
               output count, event_p, pin_o, pin_oe_n);
endinterface : ttp_chan_if

// File: ttp_pin_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Outside devices on the three timer pins
// ----------------------------------------------------------------
module ttp_pin_partner (
  input wire logic aclk,
  input wire logic stop_state,
  input wire logic [2:0] pin_o,
  input wire logic [2:0] pin_oe_n,
  input wire logic [2:0] drv_en,
  input wire logic [2:0] drv_val,
  output logic [2:0] pin_w
);
  logic [2:0] last = 3'h0;
  logic [2:0] float_lvl;
  assign float_lvl = stop_state ? pin_o : ~last;
  assign pin_w = (~pin_oe_n & pin_o) | (pin_oe_n & drv_en & drv_val)
               | (pin_oe_n & ~drv_en & float_lvl);
  // Undriven wire toggles, except in stop where it keeps pin_o, so a stale level never reads as valid
  always_ff @(posedge aclk) begin
    last <= pin_w;
  end
endmodule : ttp_pin_partner

// File: ttp_pkg.sv
package ttp_pkg;
  localparam int NUM_TIMERS = 3;
  localparam int AXI_AW = 8;
  localparam int CNT_W_RST = 32;
  localparam int PRESCALE_RST = 2;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMP = 8'h04;
  localparam logic [7:0] OFF_DUTY = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_MASK = 8'h34;
  localparam logic [7:0] OFF_PINS = 8'h38;

  // ----------------------------------------------------------------
  // Control/status word fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 7;
  localparam int CS_EN = 0;
  localparam int CS_MODE = 1;
  localparam int CS_MODE_W = 3;
  localparam int CS_EXT = 4;
  localparam int CS_DIR = 5;
  localparam int CS_DATA = 6;
  localparam int CS_PIN = 7;

  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [31:0] CMP_RST = 32'h0000ffff;
  localparam logic [31:0] DUTY_RST = 32'h00000000;
  localparam logic [NUM_TIMERS-1:0] MASK_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_GPIO = 3'h0,
    MODE_TIMER = 3'h1,
    MODE_PWM = 3'h2,
    MODE_WDOG = 3'h3,
    MODE_EVENT = 3'h4,
    MODE_MEASURE = 3'h5
  } ttp_mode_t;
endpackage : ttp_pkg

// File: ttp_timer.sv
`timescale 1ns/1ps
module ttp_timer #(
  parameter int CNT_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  ttp_chan_if.tmr ch
);
  import ttp_pkg::*;

  logic pin_prev;
  logic ext_prev;
  logic [CNT_W-1:0] count;
  logic toggle_lvl;
  logic wdog_fired;
  logic event_p;
  logic pin_o;
  logic pin_oe_n;

  // ----------------------------------------------------------------
  // Count source and compare
  // ----------------------------------------------------------------
  wire pin_rise = ch.pin_in & ~pin_prev;
  wire pin_fall = ~ch.pin_in & pin_prev;
  wire ext_rise = ch.ext_in & ~ext_prev;
  wire is_gpio = ch.mode == MODE_GPIO;
  wire is_meas = ch.mode == MODE_MEASURE;
  wire is_out_mode = (ch.mode == MODE_TIMER) | (ch.mode == MODE_PWM) | (ch.mode == MODE_WDOG);
  wire is_in_mode = (ch.mode == MODE_EVENT) | is_meas;
  wire src_tick = ch.ext_sel ? ext_rise : ch.tick;
  // Stop freezes the count, as the clocks of the real part would be halted
  wire run = ch.en & ~ch.stop & ~is_gpio;
  wire cnt_step = run & ((ch.mode == MODE_EVENT) ? pin_rise :
                         is_meas ? (src_tick & ch.pin_in) : src_tick);
  wire wrap = cnt_step & (count == ch.cmp);
  // measurement ends on the pin falling
  wire meas_done = run & is_meas & pin_fall;
  wire restart = ~ch.en | (run & is_meas & pin_rise);
  wire [CNT_W-1:0] next_count = (restart | wrap) ? '0 : cnt_step ? count + 1'b1 : count;
  wire next_lvl = (ch.mode == MODE_PWM) ? (count < ch.duty) :
                  (ch.mode == MODE_WDOG) ? wdog_fired : toggle_lvl;
  // output modes drive, general-purpose follows dir and data
  wire next_oe_n = is_gpio ? ~ch.dir : ~is_out_mode;
  wire next_pin_o = is_gpio ? ch.data : is_out_mode ? next_lvl : pin_o;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev <= 1'b0;
      ext_prev <= 1'b0;
      count <= '0;
      event_p <= 1'b0;
    end else begin
      pin_prev <= ch.pin_in;
      ext_prev <= ch.ext_in;
      count <= next_count;
      event_p <= wrap | meas_done;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ch.en) begin
      toggle_lvl <= 1'b0;
      wdog_fired <= 1'b0;
    end else begin
      if (wrap && ch.mode == MODE_TIMER) begin
        toggle_lvl <= ~toggle_lvl;
      end
      if (wrap && ch.mode == MODE_WDOG) begin
        wdog_fired <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin driver
  // ----------------------------------------------------------------
  // Stop releases the driver; pin_o keeps the last level as the keeper would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe_n <= 1'b1;
      pin_o <= 1'b0;
    end else if (ch.stop) begin
      pin_oe_n <= 1'b1;
    end else begin
      pin_oe_n <= next_oe_n;
      pin_o <= next_pin_o;
    end
  end

  assign ch.count = count;
  assign ch.event_p = event_p;
  assign ch.pin_o = pin_o;
  assign ch.pin_oe_n = pin_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_hit;
    wrap;
  endsequence

  a_stop_pin_hold: assert property (ch.stop |=> (pin_oe_n && $stable(pin_o)))
    else $error("pin not held in stop");
  a_input_mode_pin: assert property ((!ch.stop && is_in_mode) |=> pin_oe_n)
    else $error("pin driven in input mode");
  a_output_mode_pin: assert property ((!ch.stop && is_out_mode) |=> !pin_oe_n)
    else $error("pin not driven in output mode");
  a_gpio_dir_data: assert property ((!ch.stop && is_gpio) |=>
    (pin_oe_n == !$past(ch.dir)) && (!$past(ch.dir) || pin_o == $past(ch.data)))
    else $error("gpio pin disagrees with dir or data");
  a_count_wrap: assert property (s_hit |=> (count == '0 && event_p))
    else $error("compare hit without wrap and event");
endmodule : ttp_timer

// File: ttp_top.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module ttp_top #(
  parameter int CNT_W = ttp_pkg::CNT_W_RST,
  parameter int PRESCALE = ttp_pkg::PRESCALE_RST
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ttp_pkg::AXI_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ttp_pkg::AXI_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic timer0_pin_i,
  output logic timer0_pin_o,
  output logic timer0_pin_oe_n,
  input wire logic timer1_pin_i,
  output logic timer1_pin_o,
  output logic timer1_pin_oe_n,
  input wire logic timer2_pin_i,
  output logic timer2_pin_o,
  output logic timer2_pin_oe_n,
  input wire logic [ttp_pkg::NUM_TIMERS-1:0] ext_clk_in,
  input wire logic stop_state,
  input wire logic wait_state,
  output logic irq
);
  import ttp_pkg::*;

  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [NUM_TIMERS-1:0] pin_s1;
  logic [NUM_TIMERS-1:0] pin_s2;
  logic [NUM_TIMERS-1:0] pin_seen;
  logic [NUM_TIMERS-1:0] ext_s1;
  logic [NUM_TIMERS-1:0] ext_s2;
  logic [NUM_TIMERS-1:0] ext_seen;
  logic [15:0] presc_cnt;
  logic tick;
  logic [NUM_TIMERS-1:0] status;
  logic [NUM_TIMERS-1:0] mask;
  logic [NUM_TIMERS-1:0] ev_vec;
  logic [NUM_TIMERS-1:0] pin_o_v;
  logic [NUM_TIMERS-1:0] pin_oe_v;
  logic [NUM_TIMERS-1:0] rd_ch_hit;
  logic [NUM_TIMERS-1:0] wr_ch_hit;
  logic [31:0] rd_acc [NUM_TIMERS+1];

  // Wait has no path into this block, so it cannot disturb the pins
  // wait state ignored
  wire unused_inputs = &{awprot, arprot, wait_state};

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_fire = ~awready & ~wready & ~bvalid;
  wire ar_fire = arvalid & arready;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire wr_sel_status = aw_addr == OFF_STATUS;
  wire wr_sel_mask = aw_addr == OFF_MASK;
  wire wr_sel_pins = aw_addr == OFF_PINS;
  wire wr_hit = (|wr_ch_hit) | wr_sel_status | wr_sel_mask | wr_sel_pins;
  wire ar_sel_status = araddr == OFF_STATUS;
  wire ar_sel_mask = araddr == OFF_MASK;
  wire ar_sel_pins = araddr == OFF_PINS;
  wire rd_hit = (|rd_ch_hit) | ar_sel_status | ar_sel_mask | ar_sel_pins;
  wire rd_clr = ar_fire & ar_sel_status;
  wire [31:0] rd_word = ar_sel_status ? 32'(status) :
                        ar_sel_mask ? 32'(mask) :
                        ar_sel_pins ? 32'(pin_seen) : rd_acc[NUM_TIMERS];
  wire [NUM_TIMERS-1:0] next_mask = NUM_TIMERS'((32'(mask) & ~wmask) | (w_data & wmask));
  // Set wins over the read clear so no event is lost
  wire [NUM_TIMERS-1:0] next_status = ev_vec | (status & {NUM_TIMERS{~rd_clr}});

  assign rd_acc[0] = 32'h00000000;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers, prescaler, interrupt
  // ----------------------------------------------------------------
  // in Stop the sampled pin levels freeze, so input pins are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_seen <= '0;
      ext_s1 <= '0;
      ext_s2 <= '0;
      ext_seen <= '0;
    end else begin
      pin_s1 <= {timer2_pin_i, timer1_pin_i, timer0_pin_i};
      pin_s2 <= pin_s1;
      ext_s1 <= ext_clk_in;
      ext_s2 <= ext_s1;
      if (!stop_state) begin
        pin_seen <= pin_s2;
        ext_seen <= ext_s2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      presc_cnt <= 16'h0000;
    end else if (!stop_state) begin
      presc_cnt <= presc_cnt + 16'h0001;
    end
  end

  assign tick = (presc_cnt == 16'(PRESCALE - 1)) & ~stop_state;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
      mask <= MASK_RST;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(status & mask);
      if (wr_fire && wr_sel_mask) begin
        mask <= next_mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer channels
  // ----------------------------------------------------------------
  // one independent channel per timer
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_ch
    localparam logic [7:0] BASE = 8'(CH_STRIDE * i);
    logic [CTRL_W-1:0] ctrl_stat;
    logic [CNT_W-1:0] cmp;
    logic [CNT_W-1:0] duty;
    logic [31:0] rd_ch;
    ttp_chan_if #(.CNT_W(CNT_W)) chi ();

    wire wr_ctrl = wr_fire & (aw_addr == BASE + OFF_CTRL);
    wire wr_cmp = wr_fire & (aw_addr == BASE + OFF_CMP);
    wire wr_duty = wr_fire & (aw_addr == BASE + OFF_DUTY);
    wire ar_ctrl = araddr == BASE + OFF_CTRL;
    wire ar_cmp = araddr == BASE + OFF_CMP;
    wire ar_duty = araddr == BASE + OFF_DUTY;
    wire ar_count = araddr == BASE + OFF_COUNT;
    wire [31:0] m_ctrl = (32'(ctrl_stat) & ~wmask) | (w_data & wmask);
    wire [31:0] m_cmp = (32'(cmp) & ~wmask) | (w_data & wmask);
    wire [31:0] m_duty = (32'(duty) & ~wmask) | (w_data & wmask);

    assign wr_ch_hit[i] = (aw_addr == BASE + OFF_CTRL) | (aw_addr == BASE + OFF_CMP) |
                          (aw_addr == BASE + OFF_DUTY) | (aw_addr == BASE + OFF_COUNT);
    assign rd_ch_hit[i] = ar_ctrl | ar_cmp | ar_duty | ar_count;
    // pin level readable beside the control bits
    assign rd_ch = ar_ctrl ? 32'({pin_seen[i], ctrl_stat}) :
                   ar_cmp ? 32'(cmp) :
                   ar_duty ? 32'(duty) :
                   ar_count ? 32'(chi.count) : 32'h00000000;
    assign rd_acc[i+1] = rd_acc[i] | rd_ch;

    // reset leaves the pin a general-purpose input
    // control writes choose direction or timer function
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_stat <= CTRL_RST;
        cmp <= CNT_W'(CMP_RST);
        duty <= CNT_W'(DUTY_RST);
      end else begin
        if (wr_ctrl) begin
          ctrl_stat <= m_ctrl[CTRL_W-1:0];
        end
        if (wr_cmp) begin
          cmp <= m_cmp[CNT_W-1:0];
        end
        if (wr_duty) begin
          duty <= m_duty[CNT_W-1:0];
        end
      end
    end

    assign chi.en = ctrl_stat[CS_EN];
    assign chi.mode = ttp_mode_t'(ctrl_stat[CS_MODE +: CS_MODE_W]);
    assign chi.ext_sel = ctrl_stat[CS_EXT];
    assign chi.dir = ctrl_stat[CS_DIR];
    assign chi.data = ctrl_stat[CS_DATA];
    assign chi.cmp = cmp;
    assign chi.duty = duty;
    assign chi.tick = tick;
    assign chi.pin_in = pin_seen[i];
    assign chi.ext_in = ext_seen[i];
    assign chi.stop = stop_state;
    assign ev_vec[i] = chi.event_p;
    assign pin_o_v[i] = chi.pin_o;
    assign pin_oe_v[i] = chi.pin_oe_n;

    ttp_timer #(.CNT_W(CNT_W)) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .ch(chi.tmr)
    );
  end

  assign timer0_pin_o = pin_o_v[0];
  assign timer0_pin_oe_n = pin_oe_v[0];
  assign timer1_pin_o = pin_o_v[1];
  assign timer1_pin_oe_n = pin_oe_v[1];
  assign timer2_pin_o = pin_o_v[2];
  assign timer2_pin_oe_n = pin_oe_v[2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_ev_unmasked;
    (|(ev_vec & mask)) && !wr_fire;
  endsequence

  a_reset_pins_input: assert property (disable iff (1'b0) !aresetn |=> (pin_oe_v == 3'h7))
    else $error("pin not input after reset");
  a_stop_input_frozen: assert property (stop_state |=> $stable(pin_seen))
    else $error("input sampled during stop");
  a_wait_no_change: assert property (($changed(wait_state) && $stable(stop_state) &&
    !$past(wr_fire)) |=> $stable(pin_oe_v))
    else $error("wait changed pin direction");
  a_event_raises_irq: assert property (s_ev_unmasked |=> ##1 irq)
    else $error("unmasked event did not raise irq");
endmodule : ttp_top
